// >>> logic/sfh_pkg.sv
// register map, instruction format, constants and carrier types of the sequence host
package sfh_pkg;

  // register offsets
  localparam logic [11:0] OFF_MODULE_CONTROL_ZERO = 12'h000;
  localparam logic [11:0] OFF_BUS_PATH_CONTROL    = 12'h004;
  localparam logic [11:0] OFF_IP_ADDRESS          = 12'h008;
  localparam logic [11:0] OFF_IP_COMMAND          = 12'h00C;
  localparam logic [11:0] OFF_IP_TX_DATA          = 12'h010;
  localparam logic [11:0] OFF_IP_RX_LOW           = 12'h014;
  localparam logic [11:0] OFF_IP_RX_HIGH          = 12'h018;
  localparam logic [11:0] OFF_STATUS              = 12'h01C;
  localparam logic [11:0] OFF_TABLE_LOCK_KEY      = 12'h020;
  localparam logic [11:0] OFF_TABLE_LOCK_CONTROL  = 12'h024;
  localparam logic [3:0]  TABLE_PAGE              = 4'h2;

  // field positions
  localparam int MODULE_DISABLE_BIT = 0;
  localparam int SOFT_RESET_BIT     = 1;
  localparam int IP_START_BIT       = 8;
  localparam int ST_BUSY_BIT        = 0;
  localparam int ST_IP_DONE_BIT     = 1;
  localparam int ST_SEQ_ERR_BIT     = 2;
  localparam int ST_LOCKED_BIT      = 3;

  // reset values
  localparam logic MODULE_DISABLE_RST = 1'b1;
  localparam logic LOCKED_RST         = 1'b0;

  // key and lock codes, flash space limit
  localparam logic [31:0] TABLE_KEY        = 32'h5AF05AF0;
  localparam logic [1:0]  LOCK_CODE        = 2'h1;
  localparam logic [1:0]  UNLOCK_CODE      = 2'h2;
  localparam logic [31:0] FLASH_SPACE_LIMIT = 32'h10000000;

  // opcodes and the 24-bit row address argument
  localparam logic [5:0] OP_STOP                            = 6'h00;
  localparam logic [5:0] OP_SEND_COMMAND_SINGLE_RATE        = 6'h01;
  localparam logic [5:0] OP_SEND_ROW_ADDRESS_SINGLE_RATE    = 6'h02;
  localparam logic [5:0] OP_SEND_COLUMN_ADDRESS_SINGLE_RATE = 6'h03;
  localparam logic [5:0] OP_WRITE_DATA_SINGLE_RATE          = 6'h08;
  localparam logic [5:0] OP_READ_DATA_SINGLE_RATE           = 6'h09;
  localparam logic [7:0] ROW_ADDR_24                        = 8'h18;

  typedef enum logic [1:0] {
    SFH_IDLE  = 2'b00,
    SFH_FETCH = 2'b01,
    SFH_SHIFT = 2'b10,
    SFH_DONE  = 2'b11
  } sfh_eng_t;

  typedef struct packed {
    logic [5:0] opcode;
    logic [1:0] line_width_code;
    logic [7:0] instruction_argument;
  } sfh_inst_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [63:0] wdata;
  } sfh_mm_req_t;

  typedef struct packed {
    logic        ready;
    logic        err;
    logic [63:0] rdata;
  } sfh_mm_rsp_t;

  typedef struct packed {
    logic [1:0]  sclk;
    logic [3:0]  cs_n;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } sfh_pins_t;

endpackage

// >>> logic/sfh_seq_host.sv
// sequence host: register slave, instruction table, sequence engine and flash pins
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module sfh_seq_host #(
  parameter int unsigned HALF_CYCLES = 4
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // register bus
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // memory-mapped path
  input  wire sfh_pkg::sfh_mm_req_t mm_req,
  output sfh_pkg::sfh_mm_rsp_t    mm_rsp,
  // flash pins
  output sfh_pkg::sfh_pins_t      flash_out,
  input  wire logic [15:0]        flash_dq_in
);
  import sfh_pkg::*;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        module_disable;
    logic        locked;
    logic        key_armed;
    logic [3:0]  rd_seq;
    logic [3:0]  wr_seq;
    logic [1:0]  mm_dev;
    logic [31:0] ip_addr;
    logic [3:0]  ip_seq;
    logic [1:0]  ip_dev;
    logic        ip_pend;
    logic [31:0] ip_tx;
    logic        ip_done;
    logic        seq_err;
    sfh_eng_t    st;
    logic        from_mm;
    logic        cur_err;
    logic [3:0]  seq;
    logic [2:0]  pc;
    logic [1:0]  dev;
    logic [1:0]  width;
    logic        dir_in;
    logic [63:0] sh;
    logic [6:0]  bits;
    logic [7:0]  div;
    logic        sclk;
    logic [31:0] addr;
    logic [63:0] txbuf;
    logic [63:0] rxbuf;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    sfh_mm_rsp_t mm_rsp;
    sfh_pins_t   pins;
  } sfh_state_t;

  sfh_state_t  s;
  sfh_state_t  next_s;
  // no reset on purpose: contents are undefined until software loads them
  logic [15:0] lut [0:127];
  logic        lut_we;
  logic [5:0]  lut_widx;
  logic [31:0] lut_wd;
  sfh_inst_t   inst;
  logic [3:0]  lines;
  logic [7:0]  samp;
  logic [7:0]  samp_bits;
  logic [7:0]  byte_o;
  logic [7:0]  mask_o;
  logic [5:0]  col_cnt;
  logic [3:0]  byte_cnt;
  logic        acc;
  logic        wr_done;
  logic        soft_rst;
  logic        clr_done;
  logic        clr_err;
  logic        set_done;
  logic        set_err;
  logic        mapped;
  logic        active;
  logic        drv;

  assign pready    = s.pready;
  assign prdata    = s.prdata;
  assign pslverr   = s.pslverr;
  assign mm_rsp    = s.mm_rsp;
  assign flash_out = s.pins;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s    = s;
    lut_we    = 1'b0;
    lut_widx  = paddr[7:2];
    lut_wd    = pwdata;
    soft_rst  = 1'b0;
    clr_done  = 1'b0;
    clr_err   = 1'b0;
    set_done  = 1'b0;
    set_err   = 1'b0;
    col_cnt   = 6'h00;
    byte_cnt  = 4'h0;
    inst      = lut[{s.seq, s.pc}];
    lines     = 4'h1 << s.width;
    samp      = s.dev[1] ? s.dq_s2[15:8] : s.dq_s2[7:0];
    case (s.width)
      2'h0:    samp_bits = {7'h00, samp[1]};
      2'h1:    samp_bits = {6'h00, samp[1:0]};
      2'h2:    samp_bits = {4'h0, samp[3:0]};
      default: samp_bits = samp;
    endcase
    // two-stage synchroniser on the data pins
    next_s.dq_s1        = flash_dq_in;
    next_s.dq_s2        = s.dq_s1;
    next_s.mm_rsp.ready = 1'b0;

    // sequence engine
    case (s.st)
      SFH_IDLE: begin
        next_s.sclk = 1'b0;
        next_s.div  = 8'h00;
        if (!s.module_disable && s.ip_pend) begin
          next_s.ip_pend = 1'b0;
          next_s.from_mm = 1'b0;
          next_s.cur_err = 1'b0;
          next_s.seq     = s.ip_seq;
          next_s.dev     = s.ip_dev;
          next_s.addr    = s.ip_addr;
          next_s.txbuf   = {s.ip_tx, 32'h00000000};
          next_s.rxbuf   = 64'h0000000000000000;
          next_s.pc      = 3'h0;
          next_s.st      = SFH_FETCH;
        end else if (mm_req.valid && !s.mm_rsp.ready) begin
          // outside the flash space or stopped: answer at once with an error
          if (s.module_disable || mm_req.addr >= FLASH_SPACE_LIMIT) begin
            next_s.mm_rsp.ready = 1'b1;
            next_s.mm_rsp.err   = 1'b1;
          end else begin
            next_s.from_mm = 1'b1;
            next_s.cur_err = 1'b0;
            next_s.seq     = mm_req.write ? s.wr_seq : s.rd_seq;
            next_s.dev     = s.mm_dev;
            next_s.addr    = mm_req.addr;
            next_s.txbuf   = mm_req.wdata;
            next_s.rxbuf   = 64'h0000000000000000;
            next_s.pc      = 3'h0;
            next_s.st      = SFH_FETCH;
          end
        end
      end
      SFH_FETCH: begin
        next_s.width  = inst.line_width_code;
        next_s.dir_in = 1'b0;
        next_s.div    = 8'h00;
        next_s.sclk   = 1'b0;
        next_s.st     = SFH_SHIFT;
        col_cnt       = (inst.instruction_argument > 8'h20) ? 6'h20
                        : inst.instruction_argument[5:0];
        byte_cnt      = (inst.instruction_argument > 8'h08) ? 4'h8
                        : inst.instruction_argument[3:0];
        case (inst.opcode)
          OP_STOP: begin
            next_s.st = SFH_DONE;
          end
          OP_SEND_COMMAND_SINGLE_RATE: begin
            next_s.sh   = {inst.instruction_argument, 56'h00000000000000};
            next_s.bits = 7'h08;
          end
          OP_SEND_ROW_ADDRESS_SINGLE_RATE: begin
            if (inst.instruction_argument == ROW_ADDR_24) begin
              next_s.sh   = {s.addr[23:0], 40'h0000000000};
              next_s.bits = 7'h18;
            end else begin
              next_s.sh   = {s.addr, 32'h00000000};
              next_s.bits = 7'h20;
            end
          end
          OP_SEND_COLUMN_ADDRESS_SINGLE_RATE: begin
            next_s.sh   = {s.addr, 32'h00000000} << (6'h20 - col_cnt);
            next_s.bits = {1'b0, col_cnt};
          end
          OP_WRITE_DATA_SINGLE_RATE: begin
            next_s.sh   = s.txbuf;
            next_s.bits = {byte_cnt, 3'h0};
          end
          OP_READ_DATA_SINGLE_RATE: begin
            next_s.sh     = 64'h0000000000000000;
            next_s.dir_in = 1'b1;
            next_s.bits   = {byte_cnt, 3'h0};
          end
          default: begin
            set_err        = 1'b1;
            next_s.cur_err = 1'b1;
            next_s.st      = SFH_DONE;
          end
        endcase
        // an empty field moves straight to the next slot
        if (next_s.st == SFH_SHIFT && next_s.bits == 7'h00) begin
          if (s.pc == 3'h7) begin
            next_s.st = SFH_DONE;
          end else begin
            next_s.pc = s.pc + 3'h1;
            next_s.st = SFH_FETCH;
          end
        end
      end
      SFH_SHIFT: begin
        if (s.div == 8'(HALF_CYCLES - 1)) begin
          next_s.div  = 8'h00;
          next_s.sclk = ~s.sclk;
          // a beat ends on the falling edge; input is sampled just before it
          if (s.sclk) begin
            next_s.sh   = s.dir_in ? ((s.sh << lines) | {56'h00000000000000, samp_bits})
                          : (s.sh << lines);
            next_s.bits = s.bits - {3'h0, lines};
            if (s.bits <= {3'h0, lines}) begin
              next_s.bits = 7'h00;
              if (s.dir_in) begin
                next_s.rxbuf = next_s.sh;
              end
              if (s.pc == 3'h7) begin
                next_s.st = SFH_DONE;
              end else begin
                next_s.pc = s.pc + 3'h1;
                next_s.st = SFH_FETCH;
              end
            end
          end
        end else begin
          next_s.div = s.div + 8'h01;
        end
      end
      SFH_DONE: begin
        next_s.st   = SFH_IDLE;
        next_s.sclk = 1'b0;
        if (s.from_mm) begin
          next_s.mm_rsp.ready = 1'b1;
          next_s.mm_rsp.err   = s.cur_err;
          next_s.mm_rsp.rdata = s.rxbuf;
        end else begin
          set_done = 1'b1;
        end
      end
      default: begin
        next_s.st = SFH_IDLE;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // register slave: one wait state, answer registered
    acc     = psel && penable && !s.pready;
    wr_done = psel && penable && s.pready && pwrite;
    mapped  = (paddr[11:8] == TABLE_PAGE)
              || (paddr[11:6] == 6'h00 && paddr <= OFF_TABLE_LOCK_CONTROL);
    next_s.pready  = acc;
    // error flag only stands beside ready; read data holds its last value after it
    next_s.pslverr = 1'b0;
    if (acc) begin
      next_s.pslverr = !mapped || paddr[1:0] != 2'h0;
      next_s.prdata  = 32'h00000000;
      if (paddr[11:8] == TABLE_PAGE) begin
        next_s.prdata = {lut[{paddr[7:2], 1'b1}], lut[{paddr[7:2], 1'b0}]};
      end else begin
        case (paddr)
          OFF_MODULE_CONTROL_ZERO: next_s.prdata = {31'h00000000, s.module_disable};
          OFF_BUS_PATH_CONTROL:    next_s.prdata = {22'h000000, s.mm_dev, s.wr_seq, s.rd_seq};
          OFF_IP_ADDRESS:          next_s.prdata = s.ip_addr;
          OFF_IP_COMMAND:          next_s.prdata = {23'h000000, s.ip_pend, 2'h0, s.ip_dev,
                                                    s.ip_seq};
          OFF_IP_TX_DATA:          next_s.prdata = s.ip_tx;
          OFF_IP_RX_LOW:           next_s.prdata = s.rxbuf[31:0];
          OFF_IP_RX_HIGH:          next_s.prdata = s.rxbuf[63:32];
          OFF_STATUS:              next_s.prdata = {28'h0000000, s.locked, s.seq_err,
                                                    s.ip_done, s.st != SFH_IDLE};
          OFF_TABLE_LOCK_CONTROL:  next_s.prdata = {30'h00000000, !s.locked, s.locked};
          default:                 next_s.prdata = 32'h00000000;
        endcase
      end
    end
    if (wr_done) begin
      next_s.key_armed = 1'b0;
      if (paddr[11:8] == TABLE_PAGE) begin
        lut_we = !s.locked && paddr[1:0] == 2'h0;
      end else begin
        case (paddr)
          OFF_MODULE_CONTROL_ZERO: begin
            next_s.module_disable = pwdata[MODULE_DISABLE_BIT];
            soft_rst    = pwdata[SOFT_RESET_BIT];
          end
          OFF_BUS_PATH_CONTROL: begin
            next_s.rd_seq = pwdata[3:0];
            next_s.wr_seq = pwdata[7:4];
            next_s.mm_dev = pwdata[9:8];
          end
          OFF_IP_ADDRESS: next_s.ip_addr = pwdata;
          OFF_IP_COMMAND: begin
            next_s.ip_seq = pwdata[3:0];
            next_s.ip_dev = pwdata[5:4];
            if (pwdata[IP_START_BIT]) begin
              next_s.ip_pend = 1'b1;
            end
          end
          OFF_IP_TX_DATA: next_s.ip_tx = pwdata;
          OFF_STATUS: begin
            clr_done = pwdata[ST_IP_DONE_BIT];
            clr_err  = pwdata[ST_SEQ_ERR_BIT];
          end
          OFF_TABLE_LOCK_KEY: next_s.key_armed = (pwdata == TABLE_KEY);
          OFF_TABLE_LOCK_CONTROL: begin
            if (s.key_armed && pwdata[1:0] == LOCK_CODE) begin
              next_s.locked = 1'b1;
            end else if (s.key_armed && pwdata[1:0] == UNLOCK_CODE) begin
              next_s.locked = 1'b0;
            end
          end
          default: next_s.key_armed = 1'b0;
        endcase
      end
    end
    // hardware set beats a software clear in the same cycle
    next_s.ip_done = (s.ip_done && !clr_done) || set_done;
    next_s.seq_err = (s.seq_err && !clr_err) || set_err;

    // soft reset aborts the engine but keeps configuration and the table
    if (soft_rst) begin
      if (s.st != SFH_IDLE && s.from_mm) begin
        next_s.mm_rsp.ready = 1'b1;
        next_s.mm_rsp.err   = 1'b1;
      end
      next_s.st        = SFH_IDLE;
      next_s.ip_pend   = 1'b0;
      next_s.ip_done   = 1'b0;
      next_s.seq_err   = 1'b0;
      next_s.sclk      = 1'b0;
      next_s.div       = 8'h00;
      next_s.key_armed = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins follow the next state so they leave straight from flops
    active = next_s.st == SFH_FETCH || next_s.st == SFH_SHIFT;
    drv    = next_s.st == SFH_SHIFT && !next_s.dir_in;
    case (next_s.width)
      2'h0: begin
        byte_o = {7'h00, next_s.sh[63]};
        mask_o = 8'h01;
      end
      2'h1: begin
        byte_o = {6'h00, next_s.sh[63:62]};
        mask_o = 8'h03;
      end
      2'h2: begin
        byte_o = {4'h0, next_s.sh[63:60]};
        mask_o = 8'h0F;
      end
      default: begin
        byte_o = next_s.sh[63:56];
        mask_o = 8'hFF;
      end
    endcase
    if (!drv) begin
      byte_o = 8'h00;
      mask_o = 8'h00;
    end
    next_s.pins.sclk   = {next_s.sclk && next_s.dev[1], next_s.sclk && !next_s.dev[1]};
    next_s.pins.cs_n   = active ? ~(4'h1 << next_s.dev) : 4'hF;
    next_s.pins.dq_out = next_s.dev[1] ? {byte_o, 8'h00} : {8'h00, byte_o};
    next_s.pins.dq_oe  = next_s.dev[1] ? {mask_o, 8'h00} : {8'h00, mask_o};
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.module_disable      <= MODULE_DISABLE_RST;
      s.locked    <= LOCKED_RST;
      s.pins.cs_n <= 4'hF;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge pclk) begin
    if (lut_we) begin
      lut[{lut_widx, 1'b0}] <= lut_wd[15:0];
      lut[{lut_widx, 1'b1}] <= lut_wd[31:16];
    end
  end

endmodule

// >>> tb/sfh_flash_model.sv
// behavioural x1 serial flash on channel 0 device 0 for the sequence host bench
`timescale 1ns/1ns
module sfh_flash_model #(
  parameter logic [63:0] DATA = 64'h0123456789ABCDEF
) (
  // serial side
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic [15:0]      dq_in,
  // captured header and write data
  output logic [7:0]       cmd,
  output logic [23:0]      row,
  output logic [7:0]       col,
  output logic [63:0]      wdat
);
  int   cnt;
  logic line;

  // lines that are not driven show the inverse of the last value, never a held copy
  assign dq_in = {{14{~line}}, line, ~line};

  initial begin
    cnt = 0;
    line = 1'b0;
    cmd = 8'h00;
    row = 24'h000000;
    col = 8'h00;
    wdat = 64'h0;
  end

  always @(negedge cs_n) cnt = 0;
  always @(posedge cs_n) line = ~line;

  // header bits are taken at the rising edge; data is launched there, read at the fall
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (cnt < 8) cmd = {cmd[6:0], mosi};
      else if (cnt < 32) row = {row[22:0], mosi};
      else if (cnt < 40) col = {col[6:0], mosi};
      else if (cnt < 104) begin
        line = DATA[103 - cnt];
        wdat = {wdat[62:0], mosi};
      end
      cnt++;
    end
  end
endmodule

// >>> tb/sfh_seq_host_asserts.sv
// port checks of the sequence host, bound into its top module
`timescale 1ns/1ns
module sfh_seq_host_asserts
  import sfh_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 4
) (
  // clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // register bus
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  // memory-mapped path and pins
  input wire sfh_pkg::sfh_mm_req_t mm_req,
  input wire sfh_pkg::sfh_mm_rsp_t mm_rsp,
  input wire sfh_pkg::sfh_pins_t   flash_out,
  input wire logic [15:0]          flash_dq_in
);
  logic [7:0] high_cnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  // length of the high half of each serial beat on channel 0 (sclk[0])
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) high_cnt <= 8'h00;
    else high_cnt <= flash_out.sclk[0] ? high_cnt + 8'h01 : 8'h00;
  end

  sequence apb_access_s;
    psel && penable && !pready;
  endsequence

  sequence err_answer_s;
    ##[1:4] (mm_rsp.ready && mm_rsp.err);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  apb_wait_a: assert property (apb_access_s |=> pready)
    else $error("register access not answered after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("register ready held beyond one cycle");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("slave error outside ready");
  mm_range_err_a: assert property ($rose(mm_req.valid) && (mm_req.addr >= FLASH_SPACE_LIMIT)
      |-> err_answer_s)
    else $error("mapped access above flash space not refused");
  mm_ready_pulse_a: assert property (mm_rsp.ready |=> !mm_rsp.ready)
    else $error("mapped ready held beyond one cycle");
  mm_ready_req_a: assert property (mm_rsp.ready |-> mm_req.valid)
    else $error("mapped answer without request");
  rx_hold_a: assert property ($fell(mm_rsp.ready) |-> $stable(mm_rsp.rdata))
    else $error("mapped read data not held after answer");
  sclk_frame_a: assert property ($rose(flash_out.sclk[0]) |-> !(&flash_out.cs_n[1:0]))
    else $error("serial clock outside frame");
  one_device_a: assert property ($onehot0(~flash_out.cs_n))
    else $error("more than one device selected");
  sclk_half_a: assert property ($fell(flash_out.sclk[0]) |-> (high_cnt == 8'(HALF_CYCLES)))
    else $error("serial clock high half has wrong length");
  oe_idle_a: assert property ((&flash_out.cs_n) && $past(&flash_out.cs_n)
      |-> (flash_out.dq_oe == 16'h0000))
    else $error("data lines driven while no device selected");
endmodule

bind sfh_seq_host sfh_seq_host_asserts #(.HALF_CYCLES(HALF_CYCLES)) sfh_seq_host_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .mm_req(mm_req), .mm_rsp(mm_rsp), .flash_out(flash_out), .flash_dq_in(flash_dq_in)
);

// >>> tb/test_sfh_seq_host.sv
// register, lock and mapped read tests of the sequence host
`timescale 1ns/1ns
`define CHECK(name, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("Error %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module test_sfh_seq_host;
  import sfh_pkg::*;
  localparam logic [63:0] FLASH_DATA = 64'h0123456789ABCDEF;
  localparam logic [31:0] MM_ADDR    = 32'h00012340;
  localparam logic [63:0] WR_DATA    = 64'hFEDCBA9876543210;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd, word0;
  sfh_mm_req_t       mm_req;
  sfh_mm_rsp_t       mm_rsp;
  sfh_pins_t         flash_out;
  logic [15:0]       flash_dq_in;
  logic [7:0]        seen_cmd, seen_col;
  logic [23:0]       seen_row;
  logic [63:0]       mm_rd, seen_wr;
  int                mismatches, compares;

  sfh_seq_host #(.HALF_CYCLES(4)) sfh_seq_host_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mm_req(mm_req), .mm_rsp(mm_rsp), .flash_out(flash_out), .flash_dq_in(flash_dq_in));
  sfh_flash_model #(.DATA(FLASH_DATA)) sfh_flash_model_inst (
    .sclk(flash_out.sclk[0]), .cs_n(flash_out.cs_n[0]), .mosi(flash_out.dq_out[0]),
    .dq_in(flash_dq_in), .cmd(seen_cmd), .row(seen_row), .col(seen_col), .wdat(seen_wr));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] mk(input logic [5:0] op, input logic [7:0] arg);
    return {op, 2'h0, arg};
  endfunction

  task automatic complete_run();
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) mismatches++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic mm_read(input logic [31:0] a, input logic w = 1'b0,
                         input logic [63:0] d = 64'h0);
    int n;
    n = 0;
    @(posedge pclk);
    mm_req <= '{1'b1, w, a, d};
    do begin
      @(posedge pclk);
      n++;
    end while (mm_rsp.ready !== 1'b1 && n < 5000);
    mm_rd = mm_rsp.rdata;
    err = mm_rsp.err;
    mm_req.valid <= 1'b0;
    if (n >= 5000) mismatches++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // whole run is a few thousand cycles
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end

  initial begin
    mismatches = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mm_req = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    `CHECK("cs_n", 4'hF, flash_out.cs_n);
    apb(1'b0, OFF_MODULE_CONTROL_ZERO, 32'h0);
    `CHECK("module_disable", 1'b1, rd[MODULE_DISABLE_BIT]);
    apb(1'b0, 12'h100, 32'h0);
    `CHECK("unmapped_err", 1'b1, err);
    wr(OFF_MODULE_CONTROL_ZERO, 32'h1);
    wr(OFF_BUS_PATH_CONTROL, 32'h1);
    word0 = {mk(OP_SEND_ROW_ADDRESS_SINGLE_RATE, ROW_ADDR_24),
             mk(OP_SEND_COMMAND_SINGLE_RATE, 8'h03)};
    wr(12'h210, word0);
    wr(12'h214, {mk(OP_READ_DATA_SINGLE_RATE, 8'h08),
                 mk(OP_SEND_COLUMN_ADDRESS_SINGLE_RATE, 8'h08)});
    wr(12'h218, 32'h0);
    wr(12'h21C, 32'h0);
    apb(1'b0, 12'h210, 32'h0);
    `CHECK("table_word", word0, rd);
    mm_read(MM_ADDR);
    `CHECK("stop_mode_err", 1'b1, err);
    wr(OFF_MODULE_CONTROL_ZERO, 32'h0);
    mm_read(MM_ADDR);
    `CHECK("read_err", 1'b0, err);
    `CHECK("read_data", FLASH_DATA, mm_rd);
    `CHECK("command", 8'h03, seen_cmd);
    `CHECK("row", MM_ADDR[23:0], seen_row);
    `CHECK("column", MM_ADDR[7:0], seen_col);
    mm_read(FLASH_SPACE_LIMIT);
    `CHECK("range_err", 1'b1, err);
    wr(OFF_TABLE_LOCK_KEY, TABLE_KEY);
    wr(OFF_TABLE_LOCK_CONTROL, {30'h0, LOCK_CODE});
    apb(1'b0, OFF_TABLE_LOCK_CONTROL, 32'h0);
    `CHECK("lock_state", 2'b01, rd[1:0]);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHECK("status_locked", 1'b1, rd[ST_LOCKED_BIT]);
    wr(12'h210, 32'h0);
    apb(1'b0, 12'h210, 32'h0);
    `CHECK("locked_table", word0, rd);
    // a write between key and code must leave the lock in place
    wr(OFF_TABLE_LOCK_KEY, TABLE_KEY);
    wr(OFF_BUS_PATH_CONTROL, 32'h1);
    wr(OFF_TABLE_LOCK_CONTROL, {30'h0, UNLOCK_CODE});
    apb(1'b0, OFF_TABLE_LOCK_CONTROL, 32'h0);
    `CHECK("disarmed_lock", 2'b01, rd[1:0]);
    wr(OFF_TABLE_LOCK_KEY, TABLE_KEY);
    wr(OFF_TABLE_LOCK_CONTROL, {30'h0, UNLOCK_CODE});
    apb(1'b0, OFF_TABLE_LOCK_CONTROL, 32'h0);
    `CHECK("unlock_state", 2'b10, rd[1:0]);
    wr(12'h210, 32'h0);
    apb(1'b0, 12'h210, 32'h0);
    `CHECK("unlocked_table", 32'h0, rd);
    // unknown opcode through the register command path, then soft reset
    wr(12'h220, {16'h0000, mk(6'h3F, 8'h00)});
    wr(OFF_IP_COMMAND, 32'h102);
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHECK("ip_status", 4'h6, rd[3:0]);
    wr(OFF_MODULE_CONTROL_ZERO, 32'h2);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHECK("soft_reset_status", 4'h0, rd[3:0]);
    // mapped write through sequence 3
    wr(12'h230, {mk(OP_SEND_ROW_ADDRESS_SINGLE_RATE, ROW_ADDR_24),
                 mk(OP_SEND_COMMAND_SINGLE_RATE, 8'h02)});
    wr(12'h234, {mk(OP_WRITE_DATA_SINGLE_RATE, 8'h08),
                 mk(OP_SEND_COLUMN_ADDRESS_SINGLE_RATE, 8'h08)});
    wr(12'h238, 32'h0);
    wr(12'h23C, 32'h0);
    wr(OFF_BUS_PATH_CONTROL, 32'h31);
    mm_read(MM_ADDR, 1'b1, WR_DATA);
    `CHECK("write_err", 1'b0, err);
    `CHECK("write_data", WR_DATA, seen_wr);
    `CHECK("write_cmd", 8'h02, seen_cmd);
    complete_run();
  end
endmodule
